// *** dram_write_leveling_tb.sv ***
// self-checking bench for the write leveling device
module dram_write_leveling_tb
	import wl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ====
	// signals
	logic            clk_sys = 1'b0;
	logic            rst, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]      paddr, dly_up, dly_lo;
	logic [31:0]     pwdata, prdata, q;
	logic            mrs_valid, cmd_valid, odt, fire, done, ck_t;
	logic [2:0]      mrs_sel, nom;
	logic [MR_W-1:0] mrs_addr, v;
	logic            up_t, up_c, lo_t, lo_c;
	logic [15:0]     dq_out;
	logic            dq_oe_n, strobe_term_en, dq_term_en, rs_oe_n, leveling_active;
	logic [15:0]     fb_q[$];
	int              bad_count, samples_checked, k;
	int              seed = 32'ha07af4df;

	wl_device dut_u (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mrs_valid(mrs_valid), .mrs_sel(mrs_sel),
		.mrs_addr(mrs_addr), .cmd_valid(cmd_valid), .ck_t(ck_t), .odt(odt),
		.upper_byte_strobe_pair_t(up_t), .upper_byte_strobe_pair_c(up_c),
		.lower_byte_strobe_pair_t(lo_t), .lower_byte_strobe_pair_c(lo_c), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .strobe_term_en(strobe_term_en), .dq_term_en(dq_term_en),
		.read_strobe_oe_n(rs_oe_n), .leveling_active(leveling_active));
	wl_ctrl_model ctrl_u (.fire(fire), .dly_up(dly_up), .dly_lo(dly_lo), .ck_t(ck_t),
		.up_t(up_t), .up_c(up_c), .lo_t(lo_t), .lo_c(lo_c), .done(done));

	always #5 clk_sys = ~clk_sys;

	// ====
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic mrs(input logic [2:0] s, input logic [17:0] a);
		mrs_valid <= 1'b1;
		mrs_sel <= s;
		mrs_addr <= a;
		@(posedge clk_sys);
		mrs_valid <= 1'b0;
		repeat (5) @(posedge clk_sys);
	endtask

	// x16 sweeps the upper strobe with the lower fixed; otherwise the lower is swept
	task automatic sweep(input logic x16);
		int d, fb, prev, lk;
		prev = 1;
		lk = 0;
		for (d = 70; d <= 160 && lk == 0; d += 30) begin
			fb = ((d % 125) * 2 < 125) ? 1 : 0;
			fb_q.push_back(x16 ? {fb ? 8'hff : 8'h00, 8'hff} : {16{fb[0]}});
			dly_up <= x16 ? 8'(d) : 8'd30;
			dly_lo <= x16 ? 8'd30 : 8'(d);
			fire <= 1'b1;
			@(posedge clk_sys);
			fire <= 1'b0;
			do begin
				@(posedge clk_sys);
			end while (done !== 1'b1);
			repeat (8) @(posedge clk_sys);
			check("feedback", 32'(dq_out), 32'(fb_q.pop_front()));
			if (prev == 0 && fb == 1)
				lk = d;
			prev = fb;
		end
		check("lock", 32'(lk), 32'd130);
	endtask

	// ====
	// main sequence
	initial begin
		{rst, psel, penable, pwrite, mrs_valid, cmd_valid, odt, fire} = 8'h80;
		{paddr, pwdata, mrs_sel, mrs_addr, dly_up, dly_lo} = '0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, ADDR_CFG, 32'h0);
		check("cfg reset", q, CFG_RESET);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", {q[30:0], e}, 32'h1);
		apb(1'b1, ADDR_CFG, 32'h1);
		apb(1'b0, ADDR_CFG, 32'h0);
		check("cfg x16", q, 32'h1);
		check("rd strobe", 32'(rs_oe_n), 32'h1);
		mrs(MR_SEL_MR5, 18'h00080);
		for (k = 0; k < 4; k++) begin
			nom = (k == 0) ? 3'h0 : 3'($random(seed));
			v = (18'(nom) << MR1_RTT_NOM_LSB) | (18'(k % 2) << MR1_QOFF_BIT) | 18'h00080;
			mrs(MR_SEL_MR1, v);
			check("active", 32'(leveling_active), 32'h1);
			check("qoff", 32'(dq_oe_n), 32'(k % 2));
			check("undefined", 32'(dq_out), 32'h0);
			odt <= 1'b1;
			repeat (6) @(posedge clk_sys);
			check("nom term", 32'(strobe_term_en), 32'(nom != 0));
			check("dq term", 32'(dq_term_en), 32'h0);
			odt <= 1'b0;
			repeat (6) @(posedge clk_sys);
			check("park term", 32'(strobe_term_en), 32'h1);
			if (k == 2)
				apb(1'b1, ADDR_CFG, 32'h0);
			if (k == 0 || k == 2)
				sweep(k == 0);
			if (k == 1) begin
				cmd_valid <= 1'b1;
				@(posedge clk_sys);
				cmd_valid <= 1'b0;
				mrs(MR_SEL_MR5, 18'h0);
				apb(1'b0, ADDR_STATUS, 32'h0);
				check("flag", 32'(q[STAT_ILLEGAL_BIT]), 32'h1);
				apb(1'b0, ADDR_MR5, 32'h0);
				check("mr5 kept", q, 32'h80);
				apb(1'b1, ADDR_STATUS, 32'h1 << STAT_ILLEGAL_BIT);
				apb(1'b0, ADDR_STATUS, 32'h0);
				check("flag clr", 32'(q[STAT_ILLEGAL_BIT]), 32'h0);
			end
			if (k == 3) begin
				mrs(MR_SEL_MR1, v ^ 18'h01000);
				check("qoff toggle", 32'(dq_oe_n), 32'h0);
			end
			v = 18'($random(seed)) & ~18'h00080;
			mrs(MR_SEL_MR1, v);
			check("exit", 32'(leveling_active), 32'h0);
			check("released", 32'(dq_oe_n), 32'h1);
			apb(1'b0, ADDR_MR1, 32'h0);
			check("mr1 exit", q, 32'(v));
			odt <= 1'b1;
			repeat (6) @(posedge clk_sys);
			check("dq term on", 32'(dq_term_en), 32'(v[MR1_RTT_NOM_LSB +: RTT_W] != 0));
			odt <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
		tally_and_finish();
	end

	initial begin
		#100us;
		bad_count++;
		tally_and_finish();
	end
endmodule

// *** pin_sync.sv ***
// two flip-flop synchroniser for the pins that arrive from the link
module pin_sync
	import wl_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [SYNC_W-1:0] pin_in,
	output logic      [SYNC_W-1:0] pin_out
);

	logic [SYNC_W-1:0] meta_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_r  <= '0;
			pin_out <= '0;
		end else begin
			meta_r  <= pin_in;
			pin_out <= meta_r;
		end
	end

endmodule

// *** wl_ctrl_model.sv ***
// controller model: free running link clock and single delayed strobe edges
module wl_ctrl_model (
	input  wire logic       fire,
	input  wire logic [7:0] dly_up,
	input  wire logic [7:0] dly_lo,
	output logic            ck_t,
	output logic            up_t,
	output logic            up_c,
	output logic            lo_t,
	output logic            lo_c,
	output logic            done
);
	timeunit 1ns;
	timeprecision 100ps;

	// ====
	// link clock, 125 ns
	initial begin
		ck_t = 1'b0;
		#2;
		forever begin
			ck_t = ~ck_t;
			#62.5;
		end
	end

	// ====
	// strobes parked low, one rising edge per request after a clock rise
	initial begin
		{up_t, up_c, lo_t, lo_c} = 4'b0101;
		done = 1'b1;
	end

	always @(posedge fire) begin
		done = 1'b0;
		@(posedge ck_t);
		fork
			begin
				#(dly_up);
				{up_t, up_c} = 2'b10;
				#40;
				{up_t, up_c} = 2'b01;
			end
			begin
				#(dly_lo);
				{lo_t, lo_c} = 2'b10;
				#40;
				{lo_t, lo_c} = 2'b01;
			end
		join
		done = 1'b1;
	end
endmodule

// *** wl_device.sv ***
// write leveling logic of the memory device with an apb register slave
module wl_device
	import wl_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              mrs_valid,
	input  wire logic [2:0]        mrs_sel,
	input  wire logic [MR_W-1:0]   mrs_addr,
	input  wire logic              cmd_valid,
	input  wire logic              ck_t,
	input  wire logic              odt,
	input  wire logic              upper_byte_strobe_pair_t,
	input  wire logic              upper_byte_strobe_pair_c,
	input  wire logic              lower_byte_strobe_pair_t,
	input  wire logic              lower_byte_strobe_pair_c,
	output logic      [15:0]       dq_out,
	output logic                   dq_oe_n,
	output logic                   strobe_term_en,
	output logic                   dq_term_en,
	output logic                   read_strobe_oe_n,
	output logic                   leveling_active
);

	// ==========================================================
	// helpers
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADDR_CFG) || (a == ADDR_STATUS) || (a == ADDR_MR1)
			|| (a == ADDR_MR5);
	endfunction

	function automatic logic diff_high(input logic t, input logic c);
		diff_high = t & ~c;
	endfunction

	// ==========================================================
	// pin synchronisers and edge detection
	logic [SYNC_W-1:0] pins_s;
	logic              up_level_r;
	logic              lo_level_r;
	logic              up_rise;
	logic              lo_rise;
	logic              ck_s;
	logic              odt_s;

	pin_sync u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin_in  ({lower_byte_strobe_pair_c, lower_byte_strobe_pair_t,
			upper_byte_strobe_pair_c, upper_byte_strobe_pair_t, odt, ck_t}),
		.pin_out (pins_s)
	);

	assign ck_s    = pins_s[SY_CK];
	assign odt_s   = pins_s[SY_ODT];
	assign up_rise = diff_high(pins_s[SY_UP_T], pins_s[SY_UP_C]) & ~up_level_r;
	assign lo_rise = diff_high(pins_s[SY_LO_T], pins_s[SY_LO_C]) & ~lo_level_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			up_level_r <= 1'b0;
			lo_level_r <= 1'b0;
		end else begin
			up_level_r <= diff_high(pins_s[SY_UP_T], pins_s[SY_UP_C]);
			lo_level_r <= diff_high(pins_s[SY_LO_T], pins_s[SY_LO_C]);
		end
	end

	// ==========================================================
	// mode register shadows
	logic [MR_W-1:0] mr1_r;
	logic [MR_W-1:0] mr5_r;
	logic            wl_bit;
	logic            qoff_bit;
	logic            mr1_write;
	logic            mr1_exit;
	logic            mrs_illegal;
	logic            cmd_illegal;

	assign wl_bit    = mr1_r[MR1_WL_BIT];
	assign qoff_bit  = mr1_r[MR1_QOFF_BIT];
	assign mr1_write = mrs_valid && (mrs_sel == MR_SEL_MR1);
	assign mr1_exit  = mr1_write && !mrs_addr[MR1_WL_BIT];

	// while leveling only a12 may change unless a7 is being cleared
	assign mrs_illegal = wl_bit && mrs_valid && ((mrs_sel != MR_SEL_MR1)
		|| (mrs_addr[MR1_WL_BIT] && ((mrs_addr ^ mr1_r)
		& ~(18'h00001 << MR1_QOFF_BIT)) != '0));
	assign cmd_illegal = mrs_illegal || (wl_bit && cmd_valid);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mr1_r <= MR1_RESET;
		end else if (mr1_write) begin
			if (!wl_bit || mr1_exit) begin
				mr1_r <= mrs_addr;
			end else begin
				mr1_r[MR1_QOFF_BIT] <= mrs_addr[MR1_QOFF_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mr5_r <= MR5_RESET;
		end else if (mrs_valid && (mrs_sel == MR_SEL_MR5) && !wl_bit) begin
			mr5_r <= mrs_addr;
		end
	end

	// ==========================================================
	// leveling state of the data pins
	wl_state_type     state_r;
	wl_state_type     state_nxt;
	logic [CNT_W-1:0] exit_cnt_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_NORMAL: begin
				if (wl_bit) begin
					state_nxt = ST_WL_UNDEF;
				end
			end
			ST_WL_UNDEF: begin
				if (!wl_bit) begin
					state_nxt = ST_EXIT;
				end else if (up_rise || lo_rise) begin
					state_nxt = ST_WL_FB;
				end
			end
			ST_WL_FB: begin
				if (!wl_bit) begin
					state_nxt = ST_EXIT;
				end
			end
			ST_EXIT: begin
				if (wl_bit) begin
					state_nxt = ST_WL_UNDEF;
				end else if (exit_cnt_r == CNT_W'(T_MOD_CYC - 1)) begin
					state_nxt = ST_NORMAL;
				end
			end
			default: begin
				state_nxt = ST_NORMAL;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_NORMAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// counts tmod from the exit write
	always_ff @(posedge clk_sys) begin
		if (rst || state_r != ST_EXIT) begin
			exit_cnt_r <= '0;
		end else begin
			exit_cnt_r <= exit_cnt_r + CNT_W'(1);
		end
	end

	// ==========================================================
	// clock sampling and feedback
	logic fb_up_r;
	logic fb_lo_r;
	logic x16_en;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fb_up_r <= 1'b0;
			fb_lo_r <= 1'b0;
		end else if (wl_bit) begin
			if (up_rise) begin
				fb_up_r <= ck_s;
			end
			if (lo_rise) begin
				fb_lo_r <= ck_s;
			end
		end
	end

	// feedback is registered one cycle after the sampled edge, inside twlo
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dq_out <= '0;
		end else if (state_nxt == ST_WL_FB) begin
			if (x16_en) begin
				dq_out <= {{8{fb_up_r}}, {8{fb_lo_r}}};
			end else begin
				dq_out <= {16{fb_lo_r}};
			end
		end else begin
			dq_out <= '0;
		end
	end

	// data pins driven in every leveling state unless a12 disables them
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dq_oe_n <= 1'b1;
		end else begin
			dq_oe_n <= (state_nxt == ST_NORMAL) || mr1_r[MR1_QOFF_BIT];
		end
	end

	// no read strobe is returned during leveling
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			read_strobe_oe_n <= 1'b1;
		end else begin
			read_strobe_oe_n <= 1'b1;
		end
	end

	// ==========================================================
	// termination
	logic rtt_nom_set;
	logic rtt_park_set;
	logic rtt_on;

	assign rtt_nom_set  = mr1_r[MR1_RTT_NOM_LSB +: RTT_W] != '0;
	assign rtt_park_set = mr5_r[MR5_RTT_PARK_LSB +: RTT_W] != '0;
	assign rtt_on       = odt_s ? rtt_nom_set : rtt_park_set;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strobe_term_en <= 1'b0;
			dq_term_en     <= 1'b0;
		end else begin
			strobe_term_en <= rtt_on;
			dq_term_en     <= rtt_on && !wl_bit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			leveling_active <= 1'b0;
		end else begin
			leveling_active <= wl_bit;
		end
	end

	// ==========================================================
	// apb slave, one wait state per access
	logic [31:0] cfg_r;
	logic        illegal_r;
	logic        access;
	logic        wr_take;
	logic [31:0] status_val;
	logic [31:0] rd_val;

	assign access  = psel && penable && !pready;
	assign wr_take = psel && penable && pready && pwrite && is_mapped(paddr);
	assign x16_en  = cfg_r[CFG_X16_BIT];

	always_comb begin
		status_val                   = '0;
		status_val[STAT_ACTIVE_BIT]  = wl_bit;
		status_val[STAT_QOFF_BIT]    = qoff_bit;
		status_val[STAT_FB_UP_BIT]   = fb_up_r;
		status_val[STAT_FB_LO_BIT]   = fb_lo_r;
		status_val[STAT_UNDEF_BIT]   = (state_r == ST_WL_UNDEF) || (state_r == ST_EXIT);
		status_val[STAT_EXIT_BIT]    = state_r == ST_EXIT;
		status_val[STAT_ILLEGAL_BIT] = illegal_r;
		case (paddr)
			ADDR_CFG:    rd_val = cfg_r;
			ADDR_STATUS: rd_val = status_val;
			ADDR_MR1:    rd_val = {{(32 - MR_W){1'b0}}, mr1_r};
			ADDR_MR5:    rd_val = {{(32 - MR_W){1'b0}}, mr5_r};
			default:     rd_val = '0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= access;
			pslverr <= access && !is_mapped(paddr);
			prdata  <= (access && !pwrite) ? rd_val : '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_r <= CFG_RESET;
		end else if (wr_take && paddr == ADDR_CFG && pstrb[0]) begin
			cfg_r[7:0] <= pwdata[7:0];
		end
	end

	// sticky illegal command flag; cleared by writing one, a new event wins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			illegal_r <= 1'b0;
		end else if (cmd_illegal) begin
			illegal_r <= 1'b1;
		end else if (wr_take && paddr == ADDR_STATUS && pstrb[0]
			&& pwdata[STAT_ILLEGAL_BIT]) begin
			illegal_r <= 1'b0;
		end
	end

endmodule

// *** wl_device_checker.sv ***
// assertion checker for the write leveling device ports
module wl_device_checker
	import wl_pkg::*;
(
	input wire logic            clk_sys,
	input wire logic            rst,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic            mrs_valid,
	input wire logic [2:0]      mrs_sel,
	input wire logic [MR_W-1:0] mrs_addr,
	input wire logic [15:0]     dq_out,
	input wire logic            dq_oe_n,
	input wire logic            dq_term_en,
	input wire logic            read_strobe_oe_n,
	input wire logic            leveling_active
);
	// ====
	// properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic mr1_wr = mrs_valid && mrs_sel == MR_SEL_MR1;

	chk_level_enter: assert property (
		mr1_wr && mrs_addr[MR1_WL_BIT] |-> ##[1:2] leveling_active) else $error("no entry");
	chk_level_exit: assert property (
		mr1_wr && !mrs_addr[MR1_WL_BIT] |-> ##[1:2] !leveling_active) else $error("no exit");
	chk_dq_term_off: assert property (
		leveling_active && $past(leveling_active, 4) |-> !dq_term_en) else $error("dq term on");
	chk_no_rd_strobe: assert property (read_strobe_oe_n)
		else $error("read strobe driven");
	chk_exit_release: assert property (
		$fell(leveling_active) |-> ##[1:4] dq_oe_n) else $error("dq not released");
	chk_dq_idle: assert property (
		!leveling_active [*3] |-> dq_out == 16'h0) else $error("dq busy idle");
	chk_ready_wait: assert property (
		psel && penable && !$past(penable) |=> pready) else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready long");
	chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");

	cover property (mr1_wr && mrs_addr[MR1_WL_BIT]);
	cover property (pslverr);
	cover property ($fell(leveling_active));
endmodule

bind wl_device wl_device_checker chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mrs_valid(mrs_valid), .mrs_sel(mrs_sel), .mrs_addr(mrs_addr), .dq_out(dq_out),
	.dq_oe_n(dq_oe_n), .dq_term_en(dq_term_en), .read_strobe_oe_n(read_strobe_oe_n),
	.leveling_active(leveling_active));

// *** wl_pkg.sv ***
// constants, field positions and state type for the write leveling block
package wl_pkg;

	// ==========================================================
	// register offsets on the apb bus
	localparam logic [7:0]  ADDR_CFG    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_MR1    = 8'h08;
	localparam logic [7:0]  ADDR_MR5    = 8'h0c;

	// ==========================================================
	// field positions of the software registers
	localparam int          CFG_X16_BIT      = 0;
	localparam int          STAT_ACTIVE_BIT  = 0;
	localparam int          STAT_QOFF_BIT    = 1;
	localparam int          STAT_FB_UP_BIT   = 2;
	localparam int          STAT_FB_LO_BIT   = 3;
	localparam int          STAT_UNDEF_BIT   = 4;
	localparam int          STAT_EXIT_BIT    = 5;
	localparam int          STAT_ILLEGAL_BIT = 6;
	localparam logic [31:0] CFG_RESET        = 32'h0000_0000;

	// ==========================================================
	// mode register command fields
	localparam int          MR_W             = 18;
	localparam logic [2:0]  MR_SEL_MR1       = 3'h1;
	localparam logic [2:0]  MR_SEL_MR5       = 3'h5;
	localparam int          MR1_WL_BIT       = 7;
	localparam int          MR1_QOFF_BIT     = 12;
	localparam int          MR1_RTT_NOM_LSB  = 8;
	localparam int          MR5_RTT_PARK_LSB = 6;
	localparam int          RTT_W            = 3;
	localparam logic [17:0] MR1_RESET        = 18'h00000;
	localparam logic [17:0] MR5_RESET        = 18'h00000;

	// ==========================================================
	// synchroniser lane positions
	localparam int          SYNC_W  = 6;
	localparam int          SY_CK   = 0;
	localparam int          SY_ODT  = 1;
	localparam int          SY_UP_T = 2;
	localparam int          SY_UP_C = 3;
	localparam int          SY_LO_T = 4;
	localparam int          SY_LO_C = 5;

	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          T_MOD_NS      = 15;
	localparam int          T_MOD_RAW     = (T_MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          T_MOD_CYC     = (T_MOD_RAW < 1) ? 1 : T_MOD_RAW;
	localparam int          T_WLO_NS      = 9;
	localparam int          T_WLO_RAW     = T_WLO_NS / CLK_PERIOD_NS;
	localparam int          T_WLO_CYC     = (T_WLO_RAW < 1) ? 1 : T_WLO_RAW;
	localparam int          CNT_W         = 8;

	// ==========================================================
	// leveling state of the data pins
	typedef enum logic [1:0] {
		ST_NORMAL   = 2'b00,
		ST_WL_UNDEF = 2'b01,
		ST_WL_FB    = 2'b10,
		ST_EXIT     = 2'b11
	} wl_state_type;

endpackage
